/* rvs_pkg.sv */
// Purpose: Shared constants for the reset and vector sequencer
// Assumes: Main clock 100 MHz; watchdog oscillator sampled as a level
// Notes: Vector numbers double as program addresses
package rvs_pkg;
   // ==========================================================
   // Vectors
   localparam int NUM_SRC = 13;
   localparam int NUM_VEC = 14;
   localparam logic [3:0] VEC_RESET = 4'h0;
   localparam logic [3:0] VEC_EXT0 = 4'h1;
   localparam logic [3:0] VEC_COMPARATOR = 4'hd;
   // ==========================================================
   // Start-up delay counts
   localparam logic [15:0] CK_SHORT = 16'h0006;
   localparam logic [15:0] CK_MID = 16'h4000;
   localparam logic [15:0] CK_LONG = 16'h0400;
   localparam logic [16:0] WD_NONE = 17'h00000;
   localparam logic [16:0] WD_4K = 17'h01000;
   localparam logic [16:0] WD_64K = 17'h10000;
   // ==========================================================
   // Reset cause flag positions and reset value
   localparam int CAUSE_SUPPLY = 0;
   localparam int CAUSE_EXT = 1;
   localparam int CAUSE_BROWN = 2;
   localparam int CAUSE_WDOG = 3;
   localparam logic [3:0] CAUSE_RESET = 4'h0;
   // ==========================================================
   // External reset filter: pulses of 50 ns or more reset the core
   localparam int RST_MIN_NS = 50;
   localparam int CLK_NS = 10;
   localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
   // ==========================================================
   // Sequencer states
   typedef enum logic [1:0] {
      ST_HOLD,
      ST_WDOG_WAIT,
      ST_CK_WAIT,
      ST_RUN
   } rvs_state_t;
endpackage

/* rvs_vector_select.sv */
// Purpose: Priority vector selection for pending interrupts
// Assumes: Request flags are held by their peripherals
// Notes: Lowest index wins
module rvs_vector_select (
   // Requests and enables
   input wire logic [rvs_pkg::NUM_SRC-1:0] req,
   input wire logic [rvs_pkg::NUM_SRC-1:0] en,
   input wire logic global_en,
   // Result
   output logic hit,
   output logic [3:0] vec
);
   logic [rvs_pkg::NUM_SRC-1:0] live;
   // ==========================================================
   // Gate each request; per-bit loop
   genvar g;
   generate
      for (g = 0; g < rvs_pkg::NUM_SRC; g++) begin : gate
         assign live[g] = req[g] & en[g] & global_en;
      end
   endgenerate
   // Scan from the highest vector down so the lowest index wins
   always_comb begin
      hit = |live;
      vec = rvs_pkg::VEC_RESET;
      for (int i = rvs_pkg::NUM_SRC - 1; i >= 0; i--) begin
         if (live[i]) begin
            vec = 4'(i + 1);
         end
      end
   end
endmodule

/* rvs_sequencer.sv */
// Purpose: Reset combining, start-up delay and interrupt vectoring
// Assumes: All inputs synchronous to mclk; watchdog osc is a level
// Notes: Supply and brown-out detect are digital levels from analog
module rvs_sequencer (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Reset sources
   input wire logic supply_ok,
   input wire logic reset_pin_n,
   input wire logic wdog_expired,
   input wire logic wdog_enable,
   input wire logic brownout_detector,
   input wire logic brownout_enable_fuse,
   // Configuration and wake
   input wire logic [2:0] startup_delay_select,
   input wire logic watchdog_oscillator,
   input wire logic sleep_wake,
   // Reset cause software access
   input wire logic cause_wr,
   input wire logic [3:0] cause_wdata,
   output logic [3:0] reset_cause_register,
   // Interrupt side
   input wire logic [rvs_pkg::NUM_SRC-1:0] irq_req,
   input wire logic [rvs_pkg::NUM_SRC-1:0] irq_en,
   input wire logic global_ie_set,
   input wire logic instr_boundary,
   output logic global_ie,
   output logic [rvs_pkg::NUM_SRC-1:0] irq_ack,
   output logic take_vector,
   output logic [3:0] vector_addr,
   // Core reset
   output logic core_reset
);
   rvs_pkg::rvs_state_t state_reg, state_next;
   logic [16:0] wd_cnt_reg, wd_cnt_next;
   logic [15:0] ck_cnt_reg, ck_cnt_next;
   logic [3:0] pin_cnt_reg, pin_cnt_next;
   logic wosc_reg, wosc_next;
   logic wpulse_reg, wpulse_next;
   logic [3:0] cause_reg, cause_next;
   logic gie_reg, gie_next;
   logic take_reg, take_next;
   logic [3:0] vec_reg, vec_next;
   logic [rvs_pkg::NUM_SRC-1:0] ack_reg, ack_next;
   logic pin_rst, brown_rst, src_rst, hit;
   logic [3:0] sel_vec;
   logic [15:0] ck_target;
   logic [16:0] wd_target;
   logic wosc_rise;

   // ==========================================================
   // Reset source combining
   // Pin must stay low for at least the minimum width to count
   assign pin_rst = (pin_cnt_reg >= 4'(rvs_pkg::RST_MIN_CYC));
   assign brown_rst = brownout_enable_fuse & brownout_detector;
   assign src_rst = ~supply_ok | pin_rst | brown_rst | wpulse_reg;
   assign wosc_rise = watchdog_oscillator & ~wosc_reg;

   // Delay targets from the select code
   always_comb begin
      case (startup_delay_select)
         3'b000, 3'b001: ck_target = rvs_pkg::CK_SHORT;
         3'b010, 3'b011, 3'b100: ck_target = rvs_pkg::CK_MID;
         default: ck_target = rvs_pkg::CK_LONG;
      endcase
      case (startup_delay_select)
         3'b000, 3'b011, 3'b110: wd_target = rvs_pkg::WD_4K;
         3'b010, 3'b101: wd_target = rvs_pkg::WD_64K;
         default: wd_target = rvs_pkg::WD_NONE;
      endcase
   end

   // ==========================================================
   // Sequencer next state
   always_comb begin
      state_next = state_reg;
      wd_cnt_next = wd_cnt_reg;
      ck_cnt_next = ck_cnt_reg;
      wosc_next = watchdog_oscillator;
      // Saturating low-time count of the pin
      pin_cnt_next = reset_pin_n ? 4'h0 :
         (pin_rst ? pin_cnt_reg : pin_cnt_reg + 4'h1);
      // One-cycle pulse; falling edge starts the delay
      wpulse_next = wdog_enable & wdog_expired & ~wpulse_reg;
      if (src_rst) begin
         // Any source restarts the delay from scratch
         state_next = rvs_pkg::ST_HOLD;
         wd_cnt_next = 17'h00000;
         ck_cnt_next = 16'h0000;
      end else begin
         case (state_reg)
            rvs_pkg::ST_HOLD: begin
               state_next = rvs_pkg::ST_WDOG_WAIT;
            end
            rvs_pkg::ST_WDOG_WAIT: begin
               if (wd_cnt_reg >= wd_target) begin
                  state_next = rvs_pkg::ST_CK_WAIT;
               end else if (wosc_rise) begin
                  wd_cnt_next = wd_cnt_reg + 17'h00001;
               end
            end
            rvs_pkg::ST_CK_WAIT: begin
               if (ck_cnt_reg + 16'h0001 >= ck_target) begin
                  state_next = rvs_pkg::ST_RUN;
               end else begin
                  ck_cnt_next = ck_cnt_reg + 16'h0001;
               end
            end
            rvs_pkg::ST_RUN: begin
               // Wake counts clock cycles only
               if (sleep_wake) begin
                  state_next = rvs_pkg::ST_CK_WAIT;
                  ck_cnt_next = 16'h0000;
               end
            end
            default: state_next = rvs_pkg::ST_HOLD;
         endcase
      end
   end

   // Sequencer registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_reg <= rvs_pkg::ST_HOLD;
         wd_cnt_reg <= 17'h00000;
         ck_cnt_reg <= 16'h0000;
         pin_cnt_reg <= 4'h0;
         wosc_reg <= 1'b0;
         wpulse_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         wd_cnt_reg <= wd_cnt_next;
         ck_cnt_reg <= ck_cnt_next;
         pin_cnt_reg <= pin_cnt_next;
         wosc_reg <= wosc_next;
         wpulse_reg <= wpulse_next;
      end
   end

   // Core held in reset until the run state; fetch then starts at zero
   assign core_reset = (state_reg != rvs_pkg::ST_RUN) | src_rst;

   // ==========================================================
   // Reset cause flags; hardware set beats a software clear
   always_comb begin
      cause_next = cause_reg;
      if (cause_wr) begin
         cause_next = cause_reg & cause_wdata; // zero clears
      end
      if (~supply_ok) begin
         cause_next = 4'h0;
         cause_next[rvs_pkg::CAUSE_SUPPLY] = 1'b1;
      end else begin
         if (pin_rst) cause_next[rvs_pkg::CAUSE_EXT] = 1'b1;
         if (brown_rst) cause_next[rvs_pkg::CAUSE_BROWN] = 1'b1;
         if (wpulse_reg) cause_next[rvs_pkg::CAUSE_WDOG] = 1'b1;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cause_reg <= rvs_pkg::CAUSE_RESET;
      end else begin
         cause_reg <= cause_next;
      end
   end
   assign reset_cause_register = cause_reg;

   // ==========================================================
   // Interrupt vectoring
   rvs_vector_select u_sel (
      .req(irq_req),
      .en(irq_en),
      .global_en(gie_reg),
      .hit(hit),
      .vec(sel_vec)
   );

   // Evaluate once per boundary, only while the core runs
   always_comb begin
      gie_next = gie_reg;
      take_next = 1'b0;
      vec_next = vec_reg;
      ack_next = '0;
      if (core_reset) begin
         gie_next = 1'b0;
         vec_next = rvs_pkg::VEC_RESET;
      end else if (instr_boundary && hit) begin
         take_next = 1'b1;
         vec_next = sel_vec;
         gie_next = 1'b0;
         ack_next[sel_vec - rvs_pkg::VEC_EXT0] = 1'b1;
      end else if (global_ie_set) begin
         gie_next = 1'b1;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         gie_reg <= 1'b0;
         take_reg <= 1'b0;
         vec_reg <= rvs_pkg::VEC_RESET;
         ack_reg <= '0;
      end else begin
         gie_reg <= gie_next;
         take_reg <= take_next;
         vec_reg <= vec_next;
         ack_reg <= ack_next;
      end
   end
   assign global_ie = gie_reg;
   assign take_vector = take_reg;
   assign vector_addr = vec_reg;
   assign irq_ack = ack_reg;

   // ==========================================================
   // Checks
   sequence s_pulse_end;
      wpulse_reg ##1 !wpulse_reg;
   endsequence

   a_supply_drop_resets: assert property (@(posedge mclk) disable iff (rst)
      !supply_ok |-> core_reset ##1 (state_reg == rvs_pkg::ST_HOLD))
      else $error("supply drop did not reset core");
   a_brown_resets: assert property (@(posedge mclk) disable iff (rst)
      brown_rst |-> core_reset ##1 (state_reg == rvs_pkg::ST_HOLD))
      else $error("brown-out did not reset core");
   a_wdog_pulse_one: assert property (@(posedge mclk) disable iff (rst)
      wpulse_reg |=> !wpulse_reg)
      else $error("watchdog pulse longer than one cycle");
   a_pulse_restarts: assert property (@(posedge mclk) disable iff (rst)
      s_pulse_end |-> state_reg == rvs_pkg::ST_HOLD)
      else $error("delay not restarted by watchdog pulse");
   a_pin_width: assert property (@(posedge mclk) disable iff (rst)
      !reset_pin_n [*6] |=> core_reset)
      else $error("long reset pin pulse ignored");
   a_take_clears_gie: assert property (@(posedge mclk) disable iff (rst)
      take_vector |-> !global_ie)
      else $error("global enable kept on vectoring");
   a_take_needs_gie: assert property (@(posedge mclk) disable iff (rst)
      take_vector |-> $past(gie_reg) && $past(instr_boundary))
      else $error("vector taken without enable");
   a_vec_range: assert property (@(posedge mclk) disable iff (rst)
      take_vector |-> vector_addr >= rvs_pkg::VEC_EXT0
         && vector_addr <= rvs_pkg::VEC_COMPARATOR)
      else $error("vector out of range");
   a_ck_part: assert property (@(posedge mclk) disable iff (rst)
      $rose(state_reg == rvs_pkg::ST_RUN) |->
         $past(ck_cnt_reg) + 16'h0001 >= $past(ck_target))
      else $error("released before clock count done");
   a_sup_flag: assert property (@(posedge mclk) disable iff (rst)
      !supply_ok |=> reset_cause_register == 4'h1)
      else $error("supply-up flags wrong");
endmodule

/* rvs_periph_model.sv */
// Purpose: Peripheral request flags and watchdog oscillator stand-in
// Assumes: Flags are raised by bench pulses and cleared by acknowledge
// Notes: Oscillator toggles on each mclk fall, one rise per two cycles
module rvs_periph_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Request flags
   input wire logic [12:0] raise,
   input wire logic [12:0] irq_ack,
   output logic [12:0] irq_req,
   // Slow oscillator
   output logic watchdog_oscillator
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Flags stay pending until the vector is entered, like real sources
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq_req <= 13'h0000;
      end else begin
         irq_req <= (irq_req | raise) & ~irq_ack;
      end
   end
   // Free running; phase against mclk does not matter to the count
   // One driver only, parked low while the bench holds reset
   always @(negedge mclk or posedge rst) begin
      if (rst) begin
         watchdog_oscillator <= 1'b0;
      end else begin
         watchdog_oscillator <= ~watchdog_oscillator;
      end
   end
endmodule

/* tb_rvs_sequencer.sv */
// Purpose: Self-checking bench for the reset and vector sequencer
// Assumes: Inputs change on mclk falling edges only
// Notes: 64K watchdog codes are left out to keep the run short
module tb_rvs_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst, supply_ok, reset_pin_n, wdog_expired, wdog_enable;
   logic brownout_detector, brownout_enable_fuse, watchdog_oscillator;
   logic [2:0] startup_delay_select;
   logic cause_wr, global_ie_set, global_ie, take_vector, core_reset;
   logic [3:0] cause_wdata, reset_cause_register, vector_addr;
   logic [12:0] irq_req, irq_en, irq_ack, raise;
   logic sleep_wake, instr_boundary;
   int miscompares = 0;
   int cmp_count = 0;
   int cyc_total = 0;
   int cyc;
   `define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
      $display("ERROR %s exp %0h got %0h", nm, ex, got); \
      miscompares++; end end
   // ==========================================================
   // Design and far-side model
   rvs_sequencer DUT (.mclk(mclk), .rst(rst), .supply_ok(supply_ok),
      .reset_pin_n(reset_pin_n), .wdog_expired(wdog_expired),
      .wdog_enable(wdog_enable), .brownout_detector(brownout_detector),
      .brownout_enable_fuse(brownout_enable_fuse),
      .startup_delay_select(startup_delay_select),
      .watchdog_oscillator(watchdog_oscillator), .sleep_wake(sleep_wake),
      .cause_wr(cause_wr), .cause_wdata(cause_wdata),
      .reset_cause_register(reset_cause_register), .irq_req(irq_req),
      .irq_en(irq_en), .global_ie_set(global_ie_set),
      .instr_boundary(instr_boundary), .global_ie(global_ie),
      .irq_ack(irq_ack),
      .take_vector(take_vector), .vector_addr(vector_addr),
      .core_reset(core_reset));
   rvs_periph_model model (.mclk(mclk), .rst(rst), .raise(raise),
      .irq_ack(irq_ack), .irq_req(irq_req),
      .watchdog_oscillator(watchdog_oscillator));
   // ==========================================================
   // Clock and hang guard
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc_total++;
      if (cyc_total == 80000) begin
         miscompares++;
         print_verdict();
      end
   end
   // ==========================================================
   // Tasks
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Counts cycles until the core leaves reset, bounded
   task automatic wait_release(output int n);
      n = 0;
      while (core_reset !== 1'b0 && n < 20000) begin
         @(negedge mclk);
         n++;
      end
   endtask
   task automatic pin_reset(input int lo);
      reset_pin_n = 1'b0;
      repeat (lo) @(negedge mclk);
      reset_pin_n = 1'b1;
   endtask
   // Waits a few cycles for a vector to be taken, then checks it
   task automatic take_one(input int i);
      repeat (6) begin
         @(negedge mclk);
         if (take_vector === 1'b1) break;
      end
      `CHK("take", 1'b1, take_vector)
      `CHK("vector", 4'(i + 1), vector_addr)
      `CHK("ack", 13'h0001 << i, irq_ack)
      `CHK("gie", 1'b0, global_ie)
   endtask
   // ==========================================================
   // Main sequence
   int codes[5] = '{1, 7, 4, 0, 6};
   int lo_b[5] = '{6, 1024, 16384, 8198, 9216};
   initial begin
      rst = 1'b1; supply_ok = 1'b1; reset_pin_n = 1'b1;
      wdog_expired = 1'b0; wdog_enable = 1'b0; brownout_detector = 1'b0;
      brownout_enable_fuse = 1'b0; startup_delay_select = 3'h1;
      cause_wr = 1'b0; cause_wdata = 4'h0; irq_en = 13'h0000;
      global_ie_set = 1'b0; raise = 13'h0000;
      sleep_wake = 1'b0; instr_boundary = 1'b1;
      repeat (16) @(negedge mclk);
      `CHK("core held", 1'b1, core_reset)
      `CHK("reset vec", rvs_pkg::VEC_RESET, vector_addr)
      rst = 1'b0;
      wait_release(cyc);
      `CHK("first rel", 1'b1, cyc >= 6 && cyc <= 18)
      `CHK("fetch zero", rvs_pkg::VEC_RESET, vector_addr)
      // Delay per select code, started by a pin release
      foreach (codes[k]) begin
         startup_delay_select = 3'(codes[k]);
         pin_reset(8);
         `CHK("pin held", 1'b1, core_reset)
         wait_release(cyc);
         `CHK("delay", 1'b1, cyc >= lo_b[k] && cyc <= lo_b[k] + 12)
      end
      startup_delay_select = 3'h1;
      // A 30 ns glitch on the pin is filtered out
      pin_reset(3);
      repeat (3) @(negedge mclk);
      `CHK("glitch", 1'b0, core_reset)
      // Supply drop resets at once and clears other cause flags
      supply_ok = 1'b0;
      #1 `CHK("supply", 1'b1, core_reset)
      @(negedge mclk); supply_ok = 1'b1;
      wait_release(cyc);
      `CHK("sup delay", 1'b1, cyc >= 6)
      `CHK("cause", 4'h1, reset_cause_register)
      cause_wr = 1'b1; cause_wdata = 4'h0;
      @(negedge mclk); cause_wr = 1'b0;
      `CHK("cause clr", 4'h0, reset_cause_register)
      pin_reset(6); wait_release(cyc);
      `CHK("cause ext", 4'h2, reset_cause_register)
      // Brown-out only counts with the fuse programmed
      brownout_detector = 1'b1;
      repeat (3) @(negedge mclk);
      `CHK("bo off", 1'b0, core_reset)
      brownout_enable_fuse = 1'b1;
      #1 `CHK("bo on", 1'b1, core_reset)
      @(negedge mclk); brownout_detector = 1'b0;
      wait_release(cyc);
      `CHK("cause bo", 4'h6, reset_cause_register)
      // Watchdog expiry only counts while enabled
      wdog_expired = 1'b1;
      @(negedge mclk); wdog_expired = 1'b0;
      repeat (2) @(negedge mclk);
      `CHK("wd off", 1'b0, core_reset)
      wdog_enable = 1'b1; wdog_expired = 1'b1;
      @(negedge mclk); wdog_expired = 1'b0;
      wait_release(cyc);
      `CHK("wd delay", 1'b1, cyc >= 6)
      `CHK("cause wd", 4'he, reset_cause_register)
      wdog_enable = 1'b0;
      // Pending requests wait for their own enable
      raise = 13'h1fff; global_ie_set = 1'b1;
      @(negedge mclk); raise = 13'h0000; global_ie_set = 1'b0;
      repeat (3) @(negedge mclk);
      `CHK("no take", 1'b0, take_vector)
      `CHK("gie", 1'b1, global_ie)
      // Lowest index wins, one source per re-enable
      irq_en = 13'h1fff;
      for (int i = 0; i < 13; i++) begin
         if (i > 0) begin
            global_ie_set = 1'b1;
            @(negedge mclk); global_ie_set = 1'b0;
         end
         take_one(i);
      end
      repeat (4) @(negedge mclk);
      `CHK("drained", 13'h0000, irq_req)
      // Global enable off: a pending flag is remembered, not taken
      raise = 13'h0002;
      @(negedge mclk); raise = 13'h0000;
      repeat (3) @(negedge mclk);
      `CHK("gie off", 1'b0, take_vector)
      `CHK("kept", 13'h0002, irq_req)
      // No evaluation away from an instruction boundary
      instr_boundary = 1'b0; global_ie_set = 1'b1;
      @(negedge mclk); global_ie_set = 1'b0;
      repeat (3) @(negedge mclk);
      `CHK("no bound", 1'b0, take_vector)
      `CHK("gie set", 1'b1, global_ie)
      instr_boundary = 1'b1;
      take_one(1);
      // Wake from sleep skips the watchdog part of the delay
      startup_delay_select = 3'h0;
      sleep_wake = 1'b1;
      @(negedge mclk); sleep_wake = 1'b0;
      wait_release(cyc);
      `CHK("wake", 1'b1, cyc >= 6 && cyc <= 18)
      `CHK("wake cause", 4'he, reset_cause_register)
      // A second pin reset mid-delay restarts the whole count
      startup_delay_select = 3'h7;
      pin_reset(6);
      repeat (500) @(negedge mclk);
      `CHK("mid delay", 1'b1, core_reset)
      pin_reset(6);
      wait_release(cyc);
      `CHK("restart", 1'b1, cyc >= 1024 && cyc <= 1036)
      print_verdict();
   end
endmodule
